// *** sfie_defines.svh ***
// Offsets, field positions, reset values and codes of the supply fault interrupt enable block.
`ifndef SFIE_DEFINES_SVH
`define SFIE_DEFINES_SVH

// Printed register indices; the byte address is four times the index.
`define SFIE_IDX_SUPPLY_EN 8'h08
`define SFIE_IDX_BOOST_EN 8'h0a
`define SFIE_IDX_STATUS 8'h0c
`define SFIE_IDX_CLEAR 8'h0d
`define SFIE_ADDR_STRIDE 4

`define SFIE_REG_W 16
`define SFIE_NUM_FIELDS 7
`define SFIE_FIELD_W 2
`define SFIE_RSVD_LSB 14
`define SFIE_RSVD_MSB 15

`define SFIE_SUPPLY_RST 16'h2aaa
`define SFIE_BOOST_RST 16'ha028
`define SFIE_STATUS_RST 7'h00

// Two-bit field codes: bit 0 is the write strobe, bit 1 the value.
`define SFIE_CODE_DIS 2'h1
`define SFIE_CODE_EN 2'h3
`define SFIE_RD_DIS 2'h0
`define SFIE_RD_EN 2'h2

`define SFIE_RESP_OKAY 2'b00
`define SFIE_RESP_SLVERR 2'b10

`endif

// *** sfie_pkg.sv ***
// Types shared by the supply fault interrupt enable block.
package sfie_pkg;

  typedef struct packed {
    logic sync_clock_missing;
    logic charge_pump_fault;
    logic pump_cap_missing;
    logic input_overcurrent;
    logic core_undervoltage;
    logic input_overvoltage;
    logic input_undervoltage;
  } sfie_fault_t;

  typedef enum logic [2:0] {
    SFIE_SEL_SUPPLY,
    SFIE_SEL_BOOST,
    SFIE_SEL_STATUS,
    SFIE_SEL_CLEAR,
    SFIE_SEL_NONE
  } sfie_sel_t;

endpackage

// *** sfie_en_field.sv ***
// One two-bit strobe-coded interrupt enable field.
`timescale 1ns/1ps
`include "sfie_defines.svh"

module sfie_en_field #(
  parameter logic RST_EN = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_stb,
  input wire logic [1:0] wr_code,
  output logic en_ff
);
  import sfie_pkg::*;

  // Bit 0 of the code is a strobe, so codes 0h and 2h leave the field alone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff <= RST_EN;
    end else if (wr_stb && wr_code[0]) begin
      en_ff <= wr_code[1];
    end
  end

  property p_code_disable;
    @(posedge aclk) disable iff (!aresetn)
      (wr_stb && wr_code == `SFIE_CODE_DIS) |=> !en_ff;
  endproperty
  a_code_disable: assert property (p_code_disable) else $error("code 1h did not disable");

  property p_code_enable;
    @(posedge aclk) disable iff (!aresetn)
      (wr_stb && wr_code == `SFIE_CODE_EN) |=> en_ff;
  endproperty
  a_code_enable: assert property (p_code_enable) else $error("code 3h did not enable");

  property p_no_strobe_hold;
    @(posedge aclk) disable iff (!aresetn)
      (!wr_stb || !wr_code[0]) |=> $stable(en_ff);
  endproperty
  a_no_strobe_hold: assert property (p_no_strobe_hold) else $error("field changed without strobe");

endmodule

// *** sfie_supply_irq_en.sv ***
// AXI4-Lite register bank with supply fault interrupt enables, sticky status and interrupt.
//
// Functional notes
// - Supply enable register is 16 bits at index 08h, reset to 2AAAh.
// - Reading an enable field returns 0h when disabled, 2h when enabled.
// - Writing 1h into a field disables that interrupt.
// - Writing 3h into a field enables that interrupt.
// - Bits 15 to 14 are reserved, read zero and do nothing.
// - Bits 13 to 12 enable missing sync clock interrupt, reset enabled.
// - Bits 11 to 10 enable charge pump fault interrupt, reset enabled.
// - Bits 9 to 8 enable missing pump capacitor interrupt, reset enabled.
// - Bits 7 to 6 enable input over-current interrupt, reset enabled.
// - Bits 5 to 4 enable core under-voltage interrupt, reset enabled.
// - Bits 3 to 2 enable input over-voltage interrupt, reset enabled.
// - Bits 1 to 0 enable input under-voltage interrupt, reset enabled.
// - Separate 16-bit boost enable register at index 0Ah, reset A028h.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sfie_defines.svh"

module sfie_supply_irq_en #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire sfie_pkg::sfie_fault_t fault_events,
  output sfie_pkg::sfie_fault_t irq_enables,
  output logic irq
);
  import sfie_pkg::*;

  localparam int NF = `SFIE_NUM_FIELDS;
  localparam int FW = `SFIE_FIELD_W;
  // A literal cannot be bit-selected, so the reset word is given a name first.
  localparam logic [`SFIE_REG_W-1:0] SUPPLY_RST = `SFIE_SUPPLY_RST;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 6 and 32");
  end

  // Address decode shared by the write and read paths.
  function automatic sfie_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [31:0] a;
    a = 32'(addr);
    if (a == 32'(`SFIE_IDX_SUPPLY_EN) * `SFIE_ADDR_STRIDE) begin
      return SFIE_SEL_SUPPLY;
    end else if (a == 32'(`SFIE_IDX_BOOST_EN) * `SFIE_ADDR_STRIDE) begin
      return SFIE_SEL_BOOST;
    end else if (a == 32'(`SFIE_IDX_STATUS) * `SFIE_ADDR_STRIDE) begin
      return SFIE_SEL_STATUS;
    end else if (a == 32'(`SFIE_IDX_CLEAR) * `SFIE_ADDR_STRIDE) begin
      return SFIE_SEL_CLEAR;
    end
    return SFIE_SEL_NONE;
  endfunction

  // Write channel capture; address and data may arrive in either order.
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_go;
  sfie_sel_t wr_sel;

  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_sel = decode(awaddr_ff);
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= wdata;
      wstrb_ff <= wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SFIE_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel == SFIE_SEL_NONE) ? `SFIE_RESP_SLVERR : `SFIE_RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Enable fields, status bits and the clear strobes, one per fault.
  logic [NF-1:0] en_vec;
  logic [NF-1:0] status_ff;
  logic [NF-1:0] clr_vec;
  logic [NF-1:0] evt_vec;
  logic [`SFIE_REG_W-1:0] supply_word;
  logic [`SFIE_REG_W-1:0] boost_ff;

  assign evt_vec = fault_events;
  assign supply_word[`SFIE_RSVD_MSB:`SFIE_RSVD_LSB] = 2'b00;

  for (genvar i = 0; i < NF; i++) begin : g_field
    sfie_en_field #(
      .RST_EN(SUPPLY_RST[FW*i+1])
    ) u_field (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_stb(wr_go && wr_sel == SFIE_SEL_SUPPLY && wstrb_ff[i/4]),
      .wr_code(wdata_ff[FW*i +: FW]),
      .en_ff(en_vec[i])
    );
    // The stored state is one bit; it reads back as the 0h or 2h code.
    assign supply_word[FW*i +: FW] = en_vec[i] ? `SFIE_RD_EN : `SFIE_RD_DIS;
    assign clr_vec[i] = wr_go && wr_sel == SFIE_SEL_CLEAR && wstrb_ff[i/4] && wdata_ff[FW*i+1];
  end

  assign irq_enables = en_vec;

  // The boost register's fields are outside this block, so it is kept as plain storage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boost_ff <= `SFIE_BOOST_RST;
    end else if (wr_go && wr_sel == SFIE_SEL_BOOST) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_ff[b]) begin
          boost_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
        end
      end
    end
  end

  // A fault in the same cycle as its clear keeps the bit set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= `SFIE_STATUS_RST;
    end else begin
      status_ff <= (status_ff & ~clr_vec) | evt_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_ff & ~clr_vec) | evt_vec) & en_vec);
    end
  end

  // Read channel: one outstanding read, data registered.
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] status_word;
  sfie_sel_t rd_sel;

  assign arready = !rvalid_ff;
  assign rd_sel = decode(araddr);
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    status_word = 32'h0000_0000;
    for (int k = 0; k < NF; k++) begin
      status_word[FW*k+1] = status_ff[k];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `SFIE_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `SFIE_RESP_OKAY;
      unique case (rd_sel)
        SFIE_SEL_SUPPLY: rdata_ff <= {16'h0000, supply_word};
        SFIE_SEL_BOOST: rdata_ff <= {16'h0000, boost_ff};
        SFIE_SEL_STATUS: rdata_ff <= status_word;
        SFIE_SEL_CLEAR: rdata_ff <= 32'h0000_0000;
        SFIE_SEL_NONE: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `SFIE_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Helper for read checks: which register the pending read came from.
  sfie_sel_t rd_sel_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_sel_ff <= SFIE_SEL_NONE;
    end else if (arvalid && arready) begin
      rd_sel_ff <= rd_sel;
    end
  end

  property p_supply_reset;
    @(posedge aclk) !aresetn |=> (supply_word == `SFIE_SUPPLY_RST);
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("supply reset wrong");

  property p_read_codes;
    @(posedge aclk) disable iff (!aresetn)
      (rvalid_ff && rd_sel_ff == SFIE_SEL_SUPPLY) |-> (rdata_ff & 32'hffff_d555) == 32'h0000_0000;
  endproperty
  a_read_codes: assert property (p_read_codes) else $error("bad read code or bits");

  property p_read_matches;
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && rd_sel == SFIE_SEL_SUPPLY) |=> rdata_ff[15:0] == $past(supply_word);
  endproperty
  a_read_matches: assert property (p_read_matches) else $error("read data stale");

  property p_field_reset;
    @(posedge aclk) !aresetn |=> en_vec == 7'h7f;
  endproperty
  a_field_reset: assert property (p_field_reset) else $error("field reset wrong");

  property p_boost_reset;
    @(posedge aclk) !aresetn |=> boost_ff == `SFIE_BOOST_RST;
  endproperty
  a_boost_reset: assert property (p_boost_reset) else $error("boost reset wrong");

  property p_irq_masked;
    @(posedge aclk) disable iff (!aresetn)
      (en_vec == 7'h00) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all disabled");

  property p_irq_follows;
    @(posedge aclk) disable iff (!aresetn)
      ##1 irq == |(status_ff & $past(en_vec));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

  property p_event_sticks;
    @(posedge aclk) disable iff (!aresetn)
      (evt_vec != 7'h00) |=> (status_ff & $past(evt_vec)) == $past(evt_vec);
  endproperty
  a_event_sticks: assert property (p_event_sticks) else $error("event lost");

  property p_bvalid_holds;
    @(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_holds: assert property (p_bvalid_holds) else $error("bvalid dropped early");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      (aw_held_ff && w_held_ff && !bvalid_ff) |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write response");

  c_supply_write: cover property (@(posedge aclk) wr_go && wr_sel == SFIE_SEL_SUPPLY);
  c_supply_read: cover property (@(posedge aclk) rvalid && rd_sel_ff == SFIE_SEL_SUPPLY);
  c_irq_rise: cover property (@(posedge aclk) $rose(irq));
  c_set_and_clear: cover property (@(posedge aclk) (evt_vec & clr_vec) != 7'h00);

endmodule

// *** tb_top.sv ***
// Self-checking bench for the supply fault interrupt enable register bank.
`timescale 1ns/1ps
`include "sfie_defines.svh"

module tb_top;
  import sfie_pkg::*;
  localparam logic [7:0] A_SUP = 8'(`SFIE_IDX_SUPPLY_EN * `SFIE_ADDR_STRIDE);
  localparam logic [7:0] A_BST = 8'(`SFIE_IDX_BOOST_EN * `SFIE_ADDR_STRIDE);
  localparam logic [7:0] A_STS = 8'(`SFIE_IDX_STATUS * `SFIE_ADDR_STRIDE);
  localparam logic [7:0] A_CLR = 8'(`SFIE_IDX_CLEAR * `SFIE_ADDR_STRIDE);
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, exp;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  sfie_fault_t fault_events, irq_enables;
  int miscompares = 0;
  int check_count = 0;
  int i;

  sfie_supply_irq_en #(.ADDR_W(8)) i_sfie_supply_irq_en (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .fault_events(fault_events), .irq_enables(irq_enables), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask

  // Registered outputs are read 1 ns after an edge, once they have settled.
  task automatic chk_irq(input string name, input logic [31:0] expv);
    #1;
    check(name, 32'(irq), expv);
    @(posedge aclk);
  endtask

  task automatic chk_en(input string name, input logic [31:0] expv);
    #1;
    check(name, 32'(irq_enables), expv);
    @(posedge aclk);
  endtask

  // Handshakes are judged 1 ns after each edge, once the slave's outputs have settled.
  // The response readies stay high after a transfer, so back-to-back calls never assign
  // them twice in one time step.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rexp);
    logic aw_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    for (int n = 0; n < 40 && !b_ok; n++) begin
      #1;
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    if (!b_ok) begin
      miscompares++;
      give_verdict();
    end
    check("bresp", 32'(resp), 32'(rexp));
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_ok, r_ok;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    for (int n = 0; n < 40 && !r_ok; n++) begin
      #1;
      ar_ok = arvalid && arready;
      r_ok = (rvalid === 1'b1);
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    if (!r_ok) begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expv, input string name);
    logic [31:0] d;
    axi_rd(a, d);
    check(name, d, expv);
    check("rresp", 32'(resp), 32'(`SFIE_RESP_OKAY));
  endtask

  task automatic pulse_fault(input sfie_fault_t f);
    fault_events <= f;
    @(posedge aclk);
    fault_events <= '0;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    fault_events = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(A_SUP, 32'(`SFIE_SUPPLY_RST), "supply reset");
    chk_en("enables reset", 32'h0000_007f);
    rd_chk(A_BST, 32'(`SFIE_BOOST_RST), "boost reset");
    chk_irq("irq reset", 32'h0000_0000);
    $display("Test reset values done");

    for (i = 0; i < `SFIE_NUM_FIELDS; i++) begin
      exp = 32'(`SFIE_SUPPLY_RST) & ~(32'h0000_0003 << (2 * i));
      axi_wr(A_SUP, 32'(`SFIE_CODE_DIS) << (2 * i), `SFIE_RESP_OKAY);
      rd_chk(A_SUP, exp, "field disabled");
      chk_en("enable bit", 32'h0000_007f & ~(32'h1 << i));
      // Codes 2h in every field and ones in the reserved pair must change nothing.
      axi_wr(A_SUP, 32'h0000_eaaa, `SFIE_RESP_OKAY);
      rd_chk(A_SUP, exp, "code 2h kept");
      axi_wr(A_SUP, 32'h0000_0000, `SFIE_RESP_OKAY);
      rd_chk(A_SUP, exp, "code 0h kept");
      axi_wr(A_SUP, 32'(`SFIE_CODE_EN) << (2 * i), `SFIE_RESP_OKAY);
      rd_chk(A_SUP, 32'(`SFIE_SUPPLY_RST), "field enabled");
    end
    $display("Test field codes done");

    axi_wr(A_SUP, 32'(`SFIE_CODE_DIS), `SFIE_RESP_OKAY);
    pulse_fault(7'h01);
    chk_irq("irq masked", 32'h0000_0000);
    rd_chk(A_STS, 32'h0000_0002, "status sticky");
    axi_wr(A_SUP, 32'(`SFIE_CODE_EN), `SFIE_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_irq("irq enabled", 32'h0000_0001);
    axi_wr(A_CLR, 32'h0000_0002, `SFIE_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_irq("irq cleared", 32'h0000_0000);
    pulse_fault(7'h40);
    chk_irq("irq sync fault", 32'h0000_0001);
    axi_wr(A_SUP, 32'(`SFIE_CODE_DIS) << 12, `SFIE_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_irq("irq after mask", 32'h0000_0000);
    axi_wr(A_CLR, 32'h0000_2000, `SFIE_RESP_OKAY);
    axi_wr(A_SUP, 32'(`SFIE_CODE_EN) << 12, `SFIE_RESP_OKAY);
    rd_chk(A_STS, 32'h0000_0000, "status empty");
    rd_chk(A_CLR, 32'h0000_0000, "clear reads zero");
    $display("Test interrupt masking done");

    axi_wr(A_BST, 32'h0000_1234, `SFIE_RESP_OKAY);
    rd_chk(A_BST, 32'h0000_1234, "boost storage");
    rd_chk(A_SUP, 32'(`SFIE_SUPPLY_RST), "supply untouched");
    axi_rd(8'h3c, exp);
    check("unmapped rresp", 32'(resp), 32'(`SFIE_RESP_SLVERR));
    axi_wr(8'h04, 32'h0000_ffff, `SFIE_RESP_SLVERR);
    rd_chk(A_SUP, 32'(`SFIE_SUPPLY_RST), "after unmapped");
    $display("Test boost and unmapped done");
    give_verdict();
  end
endmodule
